/* dv/prs_pins_model.sv */
// Pin partner: resolves each pad from the block's drive and the outside level
`timescale 1ns/1ns
module prs_pins_model (
   input  wire logic [79:0] pin_out,
   input  wire logic [79:0] pin_oe_n,
   input  wire logic [79:0] ext_lvl,
   output logic      [79:0] pin_in
);
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule : prs_pins_model

/* dv/prs_port_read_asserts.sv */
// Checker for the port read block, bound to its ports
`timescale 1ns/1ns
module prs_port_read_asserts
   import prs_pkg::*;
(
   input wire logic         core_clk,
   input wire logic         rst,
   input wire logic [3:0]   addr,
   input wire logic [7:0]   wdata,
   input wire logic         wr,
   input wire logic         rd,
   input wire logic [7:0]   rdata,
   input wire logic [79:0]  pin_out,
   input wire logic [79:0]  pin_oe_n,
   input wire logic [79:0]  pin_chan_hit,
   input wire logic         sleep_mode,
   input wire logic         wake_req,
   input wire logic [79:0]  ana_path_on,
   input wire logic         read_back_enable
);
   import prs_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence key_wr_s;
      wr && addr == ADDR_KEY;
   endsequence
   a_key_match: assert property (key_wr_s ##0 wdata == KEY_PATTERN |=> read_back_enable)
      else $error("key write did not enable read-back");
   a_key_other: assert property (key_wr_s ##0 wdata != KEY_PATTERN |=> !read_back_enable)
      else $error("other key value left read-back on");
   a_key_hold: assert property (!(wr && addr == ADDR_KEY) |=> $stable(read_back_enable))
      else $error("read-back moved without a key write");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside its slot");
   a_uart_upper: assert property (rd && addr == ADDR_UART_SEL |=> rdata[7:4] == 4'h0)
      else $error("upper select bits not zero");
   a_reset_dflt: assert property ($past(rst) |-> &pin_out && &pin_oe_n)
      else $error("port latch or direction not high after reset");
   a_ana_forced: assert property (read_back_enable |-> ana_path_on == pin_chan_hit)
      else $error("selected channel path not forced on");
   a_ana_limit: assert property ((ana_path_on & ~pin_chan_hit) == 80'h0)
      else $error("analogue path on for unselected pin");
   a_wake_pulse: assert property (wake_req |-> $past(sleep_mode) ##1 !wake_req)
      else $error("wake pulse wrong");
endmodule : prs_port_read_asserts

bind prs_port_read prs_port_read_asserts u_chk (.core_clk(core_clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .pin_chan_hit(pin_chan_hit), .sleep_mode(sleep_mode), .wake_req(wake_req),
   .ana_path_on(ana_path_on), .read_back_enable(read_back_enable));

/* dv/prs_port_read_tb.sv */
// Self-checking bench for the port read block
`timescale 1ns/1ns
module prs_port_read_tb;
   import prs_pkg::*;
   logic         core_clk = 1'b0;
   logic         rst = 1'b1;
   logic [3:0]   addr = 4'h0;
   logic [7:0]   wdata = 8'h00;
   logic         wr = 1'b0;
   logic         rd = 1'b0;
   logic         sleep_mode = 1'b0;
   logic [79:0]  ext_lvl = 80'h0;
   logic [79:0]  pin_chan_hit = 80'h0;
   logic [159:0] pin_func = 160'h0;
   logic [7:0]   rdata;
   logic [79:0]  pin_in;
   logic [79:0]  pin_out;
   logic [79:0]  pin_oe_n;
   logic [79:0]  ana_path_on;
   logic [6:0]   outs;
   logic         wake_req;
   logic         read_back_enable;
   int           n_mismatch = 0;
   int           n_tests = 0;
   int           pulses;
   // Source pin per select code (rows) and output (uart0..2, timer4..7)
   int           pins [4][7] = '{'{6, 25, 32, 40, 41, 42, 43}, '{28, 46, 8, 65, 64, 18, 20},
                                 '{6, 25, 66, 60, 61, 62, 63}, '{28, 46, 66, 60, 61, 71, 70}};

   always #4 core_clk = ~core_clk;

   prs_port_read dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_func(pin_func), .pin_chan_hit(pin_chan_hit), .sleep_mode(sleep_mode),
      .wake_req(wake_req), .uart0_in(outs[0]), .uart1_in(outs[1]), .uart2_in(outs[2]),
      .ptimer4_clk_in(outs[3]), .ptimer5_clk_in(outs[4]), .ptimer6_clk_in(outs[5]),
      .ptimer7_clk_in(outs[6]), .ana_path_on(ana_path_on), .read_back_enable(read_back_enable));

   prs_pins_model u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl),
      .pin_in(pin_in));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr_reg

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
      @(posedge core_clk);
   endtask : rd_chk

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd_chk(ADDR_UART_SEL, UART_SEL_RST);
      rd_chk(ADDR_TMR_SEL, TMR_SEL_RST);
      rd_chk(ADDR_KEY, KEY_RST);
      rd_chk(ADDR_PORT_DATA, PORT_DATA_RST);
      rd_chk(ADDR_PORT_DIR, PORT_DIR_RST);
      rd_chk(4'hc, 8'h00);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         wr_reg(ADDR_TMR_SEL, {4{c[1:0]}});
         wr_reg(ADDR_UART_SEL, {4'hf, c[1:0], c[0], c[0]});
         rd_chk(ADDR_UART_SEL, {4'h0, c[1:0], c[0], c[0]});
         for (int j = 0; j < 7; j++) begin
            ext_lvl <= 80'h1 << pins[c][j];
            repeat (5) @(posedge core_clk);
            chk({1'b0, outs}, 8'h1 << j);
         end
      end
      $display("test select done");
      // Pin 7 analogue, pin 6 serial, low nibble driven outputs
      ext_lvl <= 80'hf0;
      pin_func[15:12] <= 4'h9;
      wr_reg(ADDR_PORT_IDX, 8'h00);
      wr_reg(ADDR_PORT_DATA, 8'h55);
      wr_reg(ADDR_PORT_DIR, 8'hf0);
      repeat (5) @(posedge core_clk);
      rd_chk(ADDR_PORT_READ, 8'h75);
      wr_reg(ADDR_KEY, KEY_PATTERN);
      rd_chk(ADDR_STATUS, 8'h01);
      rd_chk(ADDR_PORT_READ, 8'hf5);
      rd_chk(ADDR_PORT_DIR, 8'hf0);
      pin_chan_hit <= 80'h20;
      @(posedge core_clk);
      #1 chk(ana_path_on[7:0], 8'h20);
      wr_reg(ADDR_KEY, KEY_PATTERN ^ 8'h01);
      rd_chk(ADDR_STATUS, 8'h00);
      #1 chk(ana_path_on[7:0], 8'h00);
      $display("test read-back done");
      wr_reg(ADDR_BIT_SEL, 8'h07);
      wr_reg(ADDR_PORT_BSET, 8'h00);
      rd_chk(ADDR_PORT_DATA, 8'hd5);
      wr_reg(ADDR_BIT_SEL, 8'h00);
      wr_reg(ADDR_PORT_BCLR, 8'hff);
      rd_chk(ADDR_PORT_DATA, 8'hd4);
      #1 chk(pin_out[7:0], 8'hd4);
      $display("test bit ops done");
      // Four input pins fall together, only one has wake-up enabled
      sleep_mode <= 1'b1;
      wr_reg(ADDR_WAKE_EN, 8'h10);
      rd_chk(ADDR_WAKE_EN, 8'h10);
      ext_lvl <= 80'h0;
      pulses = 0;
      repeat (10) begin
         @(posedge core_clk);
         #1 pulses += int'(wake_req);
      end
      chk(8'(pulses), 8'h01);
      $display("test wake done");
      give_verdict();
   end
endmodule : prs_port_read_tb

/* pkg/prs_pkg.sv */
// Package: register map, field positions, reset values and port indices for the port read block
package prs_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   localparam int          NPORT           = 10;
   localparam int          PORT_W          = 8;
   localparam logic [3:0]  ADDR_UART_SEL   = 4'h0;
   localparam logic [3:0]  ADDR_TMR_SEL    = 4'h1;
   localparam logic [3:0]  ADDR_KEY        = 4'h2;
   localparam logic [3:0]  ADDR_STATUS     = 4'h3;
   localparam logic [3:0]  ADDR_PORT_IDX   = 4'h4;
   localparam logic [3:0]  ADDR_PORT_DATA  = 4'h5;
   localparam logic [3:0]  ADDR_PORT_DIR   = 4'h6;
   localparam logic [3:0]  ADDR_PORT_BSET  = 4'h7;
   localparam logic [3:0]  ADDR_PORT_BCLR  = 4'h8;
   localparam logic [3:0]  ADDR_PORT_READ  = 4'h9;
   localparam logic [3:0]  ADDR_WAKE_EN    = 4'ha;
   localparam logic [3:0]  ADDR_BIT_SEL    = 4'hb;
   localparam logic [7:0]  UART_SEL_RST    = 8'h00;
   localparam logic [7:0]  UART_SEL_MASK   = 8'h0f;
   localparam logic [7:0]  TMR_SEL_RST     = 8'h00;
   localparam logic [7:0]  KEY_RST         = 8'h00;
   localparam logic [7:0]  KEY_PATTERN     = 8'hca;
   localparam logic [7:0]  PORT_DATA_RST   = 8'hff;
   localparam logic [7:0]  PORT_DIR_RST    = 8'hff;
   localparam logic [7:0]  WAKE_EN_RST     = 8'h00;
   localparam int          U0_BIT          = 0;
   localparam int          U1_BIT          = 1;
   localparam int          U2_LSB          = 2;
   localparam int          T4_LSB          = 0;
   localparam int          T5_LSB          = 2;
   localparam int          T6_LSB          = 4;
   localparam int          T7_LSB          = 6;
   // Port indices A..K
   localparam int          PA = 0;
   localparam int          PB = 1;
   localparam int          PC = 2;
   localparam int          PD = 3;
   localparam int          PE = 4;
   localparam int          PF = 5;
   localparam int          PG = 6;
   localparam int          PH = 7;
   localparam int          PJ = 8;
   localparam int          PK = 9;
   // Per-pin function kinds
   localparam logic [1:0]  FN_GPIO         = 2'h0;
   localparam logic [1:0]  FN_SERIAL       = 2'h1;
   localparam logic [1:0]  FN_ANALOG       = 2'h2;
   localparam logic [1:0]  FN_RESET        = 2'h3;
endpackage : prs_pkg

/* rtl/prs_port_read.sv */
// Port read path, input source selection, keyed read-back and Port A wake-up
//
// Function
// - UART2 source: E0, B0, J2, J2
// - UART1 source bit: D1 or F6
// - UART0 source bit: A6 or D4
// - Upper four select bits read zero
// - Timer7 clock: F3, C4, H7, J6
// - Timer6 clock: F2, C2, H6, J7
// - Timer5 clock: F1, J0, H5, H5
// - Timer4 clock: F0, J1, H4, H4
// - Read-back enable only on key pattern
// - Other key values turn read-back off
// - Read-back returns live pin levels
// - Read-back touches only input path
// - Disabled: output latch, serial pins level
// - Analogue path off unless function selected or read-back on
// - Read-back forces selected channel path on
// - Reset sets data and direction high
// - Bit set/clear is read-modify-write
// - Port A falling edge wakes device
`timescale 1ns/1ns
module prs_port_read
   import prs_pkg::*;
#(
   parameter int NCHAN = 20
) (
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   input  wire logic [prs_pkg::ADDR_W-1:0]          addr,
   input  wire logic [prs_pkg::DATA_W-1:0]          wdata,
   input  wire logic                                wr,
   input  wire logic                                rd,
   output logic      [prs_pkg::DATA_W-1:0]          rdata,
   input  wire logic [prs_pkg::NPORT*prs_pkg::PORT_W-1:0] pin_in,
   output logic      [prs_pkg::NPORT*prs_pkg::PORT_W-1:0] pin_out,
   output logic      [prs_pkg::NPORT*prs_pkg::PORT_W-1:0] pin_oe_n,
   input  wire logic [2*prs_pkg::NPORT*prs_pkg::PORT_W-1:0] pin_func,
   input  wire logic [prs_pkg::NPORT*prs_pkg::PORT_W-1:0] pin_chan_hit,
   input  wire logic                                sleep_mode,
   output logic                                     wake_req,
   output logic                                     uart0_in,
   output logic                                     uart1_in,
   output logic                                     uart2_in,
   output logic                                     ptimer4_clk_in,
   output logic                                     ptimer5_clk_in,
   output logic                                     ptimer6_clk_in,
   output logic                                     ptimer7_clk_in,
   output logic      [prs_pkg::NPORT*prs_pkg::PORT_W-1:0] ana_path_on,
   output logic                                     read_back_enable
);
   import prs_pkg::*;

   localparam int NPIN = NPORT * PORT_W;

   initial begin
      if (NCHAN < 1 || NCHAN > NPIN) begin
         $error("NCHAN out of range");
      end
   end

   logic [7:0]       uart_sel_r;
   logic [7:0]       tmr_sel_r;
   logic [7:0]       key_r;
   logic [3:0]       port_idx_r;
   logic [2:0]       bit_sel_r;
   logic [7:0]       wake_en_r;
   logic [7:0]       data_r [NPORT];
   logic [7:0]       dir_r  [NPORT];
   logic [NPIN-1:0]  s1_r;
   logic [NPIN-1:0]  s2_r;
   logic [NPIN-1:0]  s3_r;
   logic [NPIN-1:0]  pin_r;
   logic [7:0]       pa_prev_r;
   logic             wake_r;
   logic [7:0]       rdata_r;
   logic [7:0]       port_view;
   logic [7:0]       rmw_val;
   logic             idx_ok;

   function automatic logic pin_at(input logic [NPIN-1:0] v, input int port, input int line);
      pin_at = v[port*PORT_W+line];
   endfunction : pin_at

   function automatic logic [1:0] fn_at(input logic [2*NPIN-1:0] f, input int idx);
      fn_at = f[2*idx +: 2];
   endfunction : fn_at

   assign idx_ok = (port_idx_r < 4'(NPORT));

   // Three-stage input sync; accept change when stages two and three agree
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         pin_r <= '0;
      end else begin
         s1_r  <= pin_in;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         pin_r <= (s2_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));
      end
   end

   assign read_back_enable = (key_r == KEY_PATTERN);

   // whole-port read, modify addressed bit, write back
   always_comb begin
      rmw_val = idx_ok ? data_r[port_idx_r] : 8'h00;
      if (addr == ADDR_PORT_BSET) begin
         rmw_val[bit_sel_r] = 1'b1;
      end else begin
         rmw_val[bit_sel_r] = 1'b0;
      end
   end

   // control registers load from the bus, act next cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         uart_sel_r <= UART_SEL_RST;
         tmr_sel_r  <= TMR_SEL_RST;
         key_r      <= KEY_RST;
         port_idx_r <= 4'h0;
         bit_sel_r  <= 3'h0;
         wake_en_r  <= WAKE_EN_RST;
      end else if (wr) begin
         case (addr)
            ADDR_UART_SEL: uart_sel_r <= wdata & UART_SEL_MASK;
            ADDR_TMR_SEL:  tmr_sel_r  <= wdata;
            ADDR_KEY:      key_r      <= wdata;
            ADDR_PORT_IDX: port_idx_r <= wdata[3:0];
            ADDR_BIT_SEL:  bit_sel_r  <= wdata[2:0];
            ADDR_WAKE_EN:  wake_en_r  <= wdata;
            default: begin
            end
         endcase
      end
   end

   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_port
         always_ff @(posedge core_clk) begin
            if (rst) begin
               data_r[gp] <= PORT_DATA_RST;
               dir_r[gp]  <= PORT_DIR_RST;
            end else if (wr && port_idx_r == 4'(gp)) begin
               if (addr == ADDR_PORT_DATA) begin
                  data_r[gp] <= wdata;
               end else if (addr == ADDR_PORT_DIR) begin
                  dir_r[gp] <= wdata;
               end else if (addr == ADDR_PORT_BSET || addr == ADDR_PORT_BCLR) begin
                  data_r[gp] <= rmw_val;
               end
            end
         end
         assign pin_out[gp*PORT_W +: PORT_W]  = data_r[gp];
         assign pin_oe_n[gp*PORT_W +: PORT_W] = dir_r[gp];
      end
   endgenerate

   // Per-pin port read value and analogue switch
   always_comb begin
      port_view = 8'h00;
      for (int b = 0; b < PORT_W; b++) begin
         if (idx_ok) begin
            if (read_back_enable) begin
               port_view[b] = pin_r[port_idx_r*PORT_W+b];
            end else begin
               case (fn_at(pin_func, port_idx_r*PORT_W+b))
                  // analogue and reset pins read zero
                  FN_ANALOG, FN_RESET: port_view[b] = 1'b0;
                  FN_SERIAL: port_view[b] = pin_r[port_idx_r*PORT_W+b];
                  // output pins give latch, inputs the pin
                  default: port_view[b] = dir_r[port_idx_r][b]
                                          ? pin_r[port_idx_r*PORT_W+b]
                                          : data_r[port_idx_r][b];
               endcase
            end
         end
      end
   end

   genvar ga;
   generate
      for (ga = 0; ga < NPIN; ga++) begin : g_ana
         // selected channel only: path on by function, or forced by read-back
         assign ana_path_on[ga] = pin_chan_hit[ga] &&
                                  (fn_at(pin_func, ga) == FN_ANALOG || read_back_enable);
      end
   endgenerate

   assign uart0_in = uart_sel_r[U0_BIT] ? pin_at(pin_r, PD, 4) : pin_at(pin_r, PA, 6);
   assign uart1_in = uart_sel_r[U1_BIT] ? pin_at(pin_r, PF, 6) : pin_at(pin_r, PD, 1);

   always_comb begin
      case (uart_sel_r[U2_LSB +: 2])
         2'h0:    uart2_in = pin_at(pin_r, PE, 0);
         2'h1:    uart2_in = pin_at(pin_r, PB, 0);
         default: uart2_in = pin_at(pin_r, PJ, 2);
      endcase
      case (tmr_sel_r[T7_LSB +: 2])
         2'h0:    ptimer7_clk_in = pin_at(pin_r, PF, 3);
         2'h1:    ptimer7_clk_in = pin_at(pin_r, PC, 4);
         2'h2:    ptimer7_clk_in = pin_at(pin_r, PH, 7);
         default: ptimer7_clk_in = pin_at(pin_r, PJ, 6);
      endcase
      case (tmr_sel_r[T6_LSB +: 2])
         2'h0:    ptimer6_clk_in = pin_at(pin_r, PF, 2);
         2'h1:    ptimer6_clk_in = pin_at(pin_r, PC, 2);
         2'h2:    ptimer6_clk_in = pin_at(pin_r, PH, 6);
         default: ptimer6_clk_in = pin_at(pin_r, PJ, 7);
      endcase
      case (tmr_sel_r[T5_LSB +: 2])
         2'h0:    ptimer5_clk_in = pin_at(pin_r, PF, 1);
         2'h1:    ptimer5_clk_in = pin_at(pin_r, PJ, 0);
         default: ptimer5_clk_in = pin_at(pin_r, PH, 5);
      endcase
      case (tmr_sel_r[T4_LSB +: 2])
         2'h0:    ptimer4_clk_in = pin_at(pin_r, PF, 0);
         2'h1:    ptimer4_clk_in = pin_at(pin_r, PJ, 1);
         default: ptimer4_clk_in = pin_at(pin_r, PH, 4);
      endcase
   end

   // falling edge on an enabled Port A pin while asleep
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pa_prev_r <= 8'h00;
         wake_r    <= 1'b0;
      end else begin
         pa_prev_r <= pin_r[PA*PORT_W +: PORT_W];
         wake_r    <= sleep_mode && |(pa_prev_r & ~pin_r[PA*PORT_W +: PORT_W] & wake_en_r);
      end
   end
   assign wake_req = wake_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (rd) begin
         case (addr)
            ADDR_UART_SEL:  rdata_r <= uart_sel_r & UART_SEL_MASK;
            ADDR_TMR_SEL:   rdata_r <= tmr_sel_r;
            ADDR_KEY:       rdata_r <= key_r;
            ADDR_STATUS:    rdata_r <= {7'h00, read_back_enable};
            ADDR_PORT_IDX:  rdata_r <= {4'h0, port_idx_r};
            ADDR_PORT_DATA: rdata_r <= idx_ok ? data_r[port_idx_r] : 8'h00;
            ADDR_PORT_DIR:  rdata_r <= idx_ok ? dir_r[port_idx_r] : 8'h00;
            ADDR_PORT_READ: rdata_r <= port_view;
            ADDR_WAKE_EN:   rdata_r <= wake_en_r;
            ADDR_BIT_SEL:   rdata_r <= {5'h00, bit_sel_r};
            default:        rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign rdata = rdata_r;

endmodule : prs_port_read
